// ===== logic/rmc_pkg.sv
// Constants, widths and state type for the regulator mode controller
`default_nettype none
package rmc_pkg;
	localparam int CLK_MHZ = 125;
	localparam int SLEEP_DELAY_US = 103;
	localparam int SLEEP_DELAY_CYC = SLEEP_DELAY_US * CLK_MHZ;
	localparam int SLEEP_CNT_W = 14;
	localparam int PFM_ENTRY_CYC = 2048;
	localparam int PFM_CNT_W = 12;
	// Base oscillator period in system clocks, fixed here in place of the frequency-set resistor
	localparam int BASE_PERIOD_CYC = 24;
	localparam int BASE_CNT_W = 5;
	localparam int SYNC_RATIO_MIN_X10 = 12;
	localparam int SYNC_RATIO_MAX_X10 = 15;
	localparam int SYNC_PERIOD_MIN_CYC = (BASE_PERIOD_CYC * 10) / SYNC_RATIO_MAX_X10;
	localparam int SYNC_PERIOD_MAX_CYC = (BASE_PERIOD_CYC * 10) / SYNC_RATIO_MIN_X10;
	localparam int SYNC_TOL_CYC = 1;
	localparam int LOCK_TIMEOUT_CYC = 2 * BASE_PERIOD_CYC;
	localparam int LOCK_GOOD_EDGES = 2;
	localparam int PER_CNT_W = 6;
	localparam int GOOD_CNT_W = 2;
	localparam int IN_SYNC_W = 8;
	localparam int IDX_SHDN = 0;
	localparam int IDX_MODE = 1;
	localparam int IDX_SS = 2;
	localparam int IDX_PG = 3;
	localparam int IDX_FAULT = 4;
	localparam int IDX_BIAS = 5;
	localparam int IDX_VIN = 6;
	localparam int IDX_TOG = 7;
	typedef enum logic [2:0] {
		ST_RESET,
		ST_SLEEP,
		ST_PWM,
		ST_PFM_WAIT,
		ST_KEEP_ALIVE,
		ST_REDUCED
	} rmc_state_t;
endpackage
`default_nettype wire

// ===== logic/rmc_sync.sv
// Two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
`default_nettype none
module rmc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic [WIDTH-1:0] i_d,
	output logic [WIDTH-1:0] o_q
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] q_reg;
	logic [WIDTH-1:0] q_next;

	always_comb begin
		meta_next = i_rstn ? i_d : '0;
		q_next = i_rstn ? meta_reg : '0;
	end

	always_ff @(posedge i_clk) begin
		meta_reg <= meta_next;
		q_reg <= q_next;
	end

	assign o_q = q_reg;
endmodule
`default_nettype wire

// ===== logic/rmc_mode_ctrl.sv
// Operating-mode controller: sleep filter, PWM / keep-alive selection, external clock lock
//
// Notes on behaviour
// - Shutdown request low must persist about 103 us before sleep is entered.
// - Regulator runs only while shutdown request is high; low means sleep, zero output.
// - Once sleep is entered, the mode select input is ignored; during the sleep filter time it still steers the mode.
// - Awake: mode select high gives base-frequency PWM, low gives keep-alive pulse mode.
// - On mode select falling, need soft-start above 2.3 V and power good, then 2048 cycles.
// - External clock on mode select locks PWM frequency; must be 1.2 to 1.5 times base.
// - Any fault or shutdown request low grounds compensation and inhibits PWM switching.
// - Bias lost with input present resets: stop switching, pull power good, SS, COMP low.
// - Keep-alive requested with fault present selects reduced-limit PWM, half limit, protection on; the fault still inhibits switching.
`timescale 1ns/1ps
`default_nettype none
module rmc_mode_ctrl #(
	parameter int SLEEP_DELAY_CYC_P = rmc_pkg::SLEEP_DELAY_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_mode_clk,
	input wire logic i_shutdown_request_n,
	input wire logic i_mode_select_input,
	input wire logic i_ss_above_pfm_en,
	input wire logic i_pg_detect,
	input wire logic i_fault,
	input wire logic i_bias_ok,
	input wire logic i_vin_ok,
	output logic o_sleep,
	output logic o_full_pwm_mode,
	output logic o_keep_alive_pulse_mode,
	output logic o_reduced_limit_pwm_mode,
	output logic o_pfm_pending,
	output logic o_switch_inhibit,
	output logic o_comp_pull_low,
	output logic o_ss_pull_low,
	output logic o_power_good_output,
	output logic o_half_current_limit,
	output logic o_protect_enable,
	output logic o_sw_clk,
	output logic o_ext_locked
);
	import rmc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Link domain: the mode pin as a clock only toggles a flag
	logic link_rstn;
	logic link_tog_reg;
	logic link_tog_next;

	rmc_sync #(.WIDTH(1)) u_link_rst (
		.i_clk(i_mode_clk),
		.i_rstn(1'h1),
		.i_d(i_rstn),
		.o_q(link_rstn)
	);

	// A stopped link clock leaves the flag frozen; the timeout below notices that
	always_comb begin
		link_tog_next = link_rstn ? ~link_tog_reg : 1'h0;
	end

	always_ff @(posedge i_mode_clk) begin
		link_tog_reg <= link_tog_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisation
	logic [IN_SYNC_W-1:0] in_raw;
	logic [IN_SYNC_W-1:0] in_s;

	assign in_raw = {link_tog_reg, i_vin_ok, i_bias_ok, i_fault, i_pg_detect,
		i_ss_above_pfm_en, i_mode_select_input, i_shutdown_request_n};

	rmc_sync #(.WIDTH(IN_SYNC_W)) u_in_sync (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_d(in_raw),
		.o_q(in_s)
	);

	logic shdn_n_s;
	logic mode_s;
	logic ss_s;
	logic pg_s;
	logic fault_s;
	logic bias_s;
	logic vin_s;
	logic tog_s;

	assign shdn_n_s = in_s[IDX_SHDN];
	assign mode_s = in_s[IDX_MODE];
	assign ss_s = in_s[IDX_SS];
	assign pg_s = in_s[IDX_PG];
	assign fault_s = in_s[IDX_FAULT];
	assign bias_s = in_s[IDX_BIAS];
	assign vin_s = in_s[IDX_VIN];
	assign tog_s = in_s[IDX_TOG];

	////////////////////////////////////////////////////////////////////////////////
	// External clock lock
	logic tog_d_reg;
	logic tog_d_next;
	logic [PER_CNT_W-1:0] per_cnt_reg;
	logic [PER_CNT_W-1:0] per_cnt_next;
	logic [GOOD_CNT_W-1:0] good_reg;
	logic [GOOD_CNT_W-1:0] good_next;
	logic locked_reg;
	logic locked_next;
	logic tog_edge;
	logic in_range;
	logic bias_reset;
	rmc_state_t state_reg;
	rmc_state_t state_next;

	assign tog_edge = tog_s ^ tog_d_reg;
	assign bias_reset = ~bias_s & vin_s;
	// Tolerance absorbs the one-cycle jitter of the crossing
	assign in_range = (per_cnt_reg >= PER_CNT_W'(SYNC_PERIOD_MIN_CYC - 1 - SYNC_TOL_CYC))
		&& (per_cnt_reg <= PER_CNT_W'(SYNC_PERIOD_MAX_CYC - 1 + SYNC_TOL_CYC));

	always_comb begin
		tog_d_next = tog_s;
		per_cnt_next = per_cnt_reg;
		good_next = good_reg;
		locked_next = locked_reg;
		if (tog_edge) begin
			per_cnt_next = '0;
		end else if (per_cnt_reg != '1) begin
			per_cnt_next = per_cnt_reg + PER_CNT_W'(1);
		end
		if (state_reg == ST_SLEEP || state_reg == ST_RESET || bias_reset || !shdn_n_s) begin
			good_next = '0;
			locked_next = 1'h0;
		end else if (tog_edge) begin
			if (in_range) begin
				if (good_reg < GOOD_CNT_W'(LOCK_GOOD_EDGES)) begin
					good_next = good_reg + GOOD_CNT_W'(1);
				end
				locked_next = (good_reg >= GOOD_CNT_W'(LOCK_GOOD_EDGES - 1));
			end else begin
				good_next = '0;
				locked_next = 1'h0;
			end
		end else if (per_cnt_reg >= PER_CNT_W'(LOCK_TIMEOUT_CYC)) begin
			good_next = '0;
			locked_next = 1'h0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			tog_d_reg <= 1'h0;
			per_cnt_reg <= '0;
			good_reg <= '0;
			locked_reg <= 1'h0;
		end else begin
			tog_d_reg <= tog_d_next;
			per_cnt_reg <= per_cnt_next;
			good_reg <= good_next;
			locked_reg <= locked_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Mode state machine
	logic [SLEEP_CNT_W-1:0] sleep_cnt_reg;
	logic [SLEEP_CNT_W-1:0] sleep_cnt_next;
	logic [PFM_CNT_W-1:0] pfm_cnt_reg;
	logic [PFM_CNT_W-1:0] pfm_cnt_next;
	logic mode_high;
	logic pfm_ok;
	logic sleep_done;

	// A locked clock counts as a high level so its low phases never start an entry
	assign mode_high = mode_s | locked_reg;
	assign pfm_ok = ss_s & pg_s;
	assign sleep_done = !shdn_n_s && (sleep_cnt_reg >= SLEEP_CNT_W'(SLEEP_DELAY_CYC_P - 1));

	always_comb begin
		state_next = state_reg;
		pfm_cnt_next = '0;
		sleep_cnt_next = '0;
		if (!shdn_n_s && sleep_cnt_reg != '1) begin
			sleep_cnt_next = sleep_cnt_reg + SLEEP_CNT_W'(1);
		end else if (!shdn_n_s) begin
			sleep_cnt_next = sleep_cnt_reg;
		end
		if (bias_reset) begin
			state_next = ST_RESET;
		end else begin
			case (state_reg)
				ST_RESET: begin
					state_next = ST_SLEEP;
				end
				ST_SLEEP: begin
					if (shdn_n_s) begin
						state_next = ST_PWM;
					end
				end
				ST_PWM: begin
					if (sleep_done) begin
						state_next = ST_SLEEP;
					end else if (!mode_high && fault_s) begin
						state_next = ST_REDUCED;
					end else if (!mode_high && pfm_ok) begin
						state_next = ST_PFM_WAIT;
					end
				end
				ST_PFM_WAIT: begin
					if (sleep_done) begin
						state_next = ST_SLEEP;
					end else if (mode_high || !pfm_ok || fault_s) begin
						state_next = ST_PWM;
					end else if (pfm_cnt_reg == PFM_CNT_W'(PFM_ENTRY_CYC - 1)) begin
						state_next = ST_KEEP_ALIVE;
					end else begin
						pfm_cnt_next = pfm_cnt_reg + PFM_CNT_W'(1);
					end
				end
				ST_KEEP_ALIVE: begin
					if (sleep_done) begin
						state_next = ST_SLEEP;
					end else if (mode_high) begin
						state_next = ST_PWM;
					end else if (fault_s) begin
						state_next = ST_REDUCED;
					end
				end
				ST_REDUCED: begin
					if (sleep_done) begin
						state_next = ST_SLEEP;
					end else if (mode_high) begin
						state_next = ST_PWM;
					end else if (!fault_s) begin
						state_next = ST_KEEP_ALIVE;
					end
				end
				default: begin
					state_next = ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state_reg <= ST_RESET;
			sleep_cnt_reg <= '0;
			pfm_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			sleep_cnt_reg <= sleep_cnt_next;
			pfm_cnt_reg <= pfm_cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Switching clock and registered outputs
	logic [BASE_CNT_W-1:0] base_cnt_reg;
	logic [BASE_CNT_W-1:0] base_cnt_next;
	logic awake;
	logic inhibit;
	logic sw_allow;
	logic clk_tick;
	logic [12:0] out_next;
	logic [12:0] out_reg;

	assign awake = (state_reg != ST_SLEEP) && (state_reg != ST_RESET) && !bias_reset;
	assign inhibit = fault_s || !shdn_n_s || !awake;
	assign sw_allow = !inhibit && (state_reg != ST_KEEP_ALIVE);
	assign clk_tick = locked_reg ? tog_edge : (base_cnt_reg == BASE_CNT_W'(BASE_PERIOD_CYC - 1));

	always_comb begin
		if (clk_tick) begin
			base_cnt_next = '0;
		end else begin
			base_cnt_next = base_cnt_reg + BASE_CNT_W'(1);
		end
		out_next[0] = (state_reg == ST_SLEEP) || (state_reg == ST_RESET);
		out_next[1] = (state_reg == ST_PWM) || (state_reg == ST_PFM_WAIT);
		out_next[2] = (state_reg == ST_KEEP_ALIVE);
		out_next[3] = (state_reg == ST_REDUCED);
		out_next[4] = (state_reg == ST_PFM_WAIT);
		out_next[5] = inhibit;
		out_next[6] = inhibit;
		out_next[7] = !awake;
		out_next[8] = pg_s && awake;
		out_next[9] = (state_reg == ST_REDUCED);
		out_next[10] = awake && (state_reg != ST_KEEP_ALIVE);
		out_next[11] = clk_tick && sw_allow;
		out_next[12] = locked_reg;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			base_cnt_reg <= '0;
			out_reg <= 13'h0001;
		end else begin
			base_cnt_reg <= base_cnt_next;
			out_reg <= out_next;
		end
	end

	assign o_sleep = out_reg[0];
	assign o_full_pwm_mode = out_reg[1];
	assign o_keep_alive_pulse_mode = out_reg[2];
	assign o_reduced_limit_pwm_mode = out_reg[3];
	assign o_pfm_pending = out_reg[4];
	assign o_switch_inhibit = out_reg[5];
	assign o_comp_pull_low = out_reg[6];
	assign o_ss_pull_low = out_reg[7];
	assign o_power_good_output = out_reg[8];
	assign o_half_current_limit = out_reg[9];
	assign o_protect_enable = out_reg[10];
	assign o_sw_clk = out_reg[11];
	assign o_ext_locked = out_reg[12];

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	sequence seq_enter_reduced;
		state_reg == ST_REDUCED ##1 (o_reduced_limit_pwm_mode && o_half_current_limit && o_protect_enable);
	endsequence

	sequence seq_reset_pulls;
		state_reg == ST_RESET && o_ss_pull_low && o_comp_pull_low && !o_power_good_output && !o_sw_clk;
	endsequence

	chk_sleep_filter_len: assert property (
		(state_reg != ST_SLEEP && state_reg != ST_RESET && state_next == ST_SLEEP && !bias_reset)
		|-> (sleep_cnt_reg == SLEEP_CNT_W'(SLEEP_DELAY_CYC_P - 1) && !shdn_n_s))
		else $error("sleep entered without full filter time");
	chk_sleep_hold: assert property (
		(state_reg == ST_SLEEP && !shdn_n_s) |=> (state_reg == ST_SLEEP || state_reg == ST_RESET)
		##1 (o_sleep && o_ss_pull_low))
		else $error("left sleep while shutdown request low");
	chk_mode_ignored: assert property (
		(state_reg == ST_SLEEP && !shdn_n_s) |=> (!locked_reg ##1 !o_ext_locked))
		else $error("mode input acted during sleep");
	chk_mode_level_pwm: assert property (
		(state_reg == ST_PWM && mode_high && !sleep_done && !bias_reset) |=> state_reg == ST_PWM ##1 o_full_pwm_mode)
		else $error("high mode select left PWM");
	chk_pfm_entry_cond: assert property (
		(state_reg == ST_PWM && state_next == ST_PFM_WAIT) |-> (ss_s && pg_s && !mode_high))
		else $error("keep-alive wait started without conditions");
	chk_pfm_count: assert property (
		(state_reg == ST_PFM_WAIT && state_next == ST_KEEP_ALIVE) |-> pfm_cnt_reg == PFM_CNT_W'(PFM_ENTRY_CYC - 1))
		else $error("keep-alive entered before 2048 cycles");
	chk_sync_tick: assert property (
		(locked_reg && tog_edge && sw_allow) |=> (o_sw_clk ##1 !o_sw_clk))
		else $error("locked switching clock missed an external edge");
	chk_fault_inhibit: assert property (
		(fault_s || !shdn_n_s) |=> (o_switch_inhibit && o_comp_pull_low && !o_sw_clk))
		else $error("fault or shutdown did not inhibit switching");
	chk_bias_reset_pull: assert property (
		bias_reset |=> seq_reset_pulls)
		else $error("bias loss did not reset the controller");
	chk_reduced_entry: assert property (
		(state_reg == ST_KEEP_ALIVE && fault_s && !mode_high && !sleep_done && !bias_reset) |=> seq_enter_reduced)
		else $error("fault in keep-alive did not select reduced limit");
	chk_pfm_abandon: assert property (
		(state_reg == ST_PFM_WAIT && (mode_high || !pfm_ok) && !sleep_done && !bias_reset)
		|=> (state_reg == ST_PWM && pfm_cnt_reg == '0))
		else $error("pending keep-alive entry not abandoned");
endmodule
`default_nettype wire

// ===== sim/rmc_host_model.sv
// Host controller model driving the shutdown request and mode select pins
`timescale 1ns/1ps
`default_nettype none
module rmc_host_model (
	output logic o_shutdown_request_n,
	output logic o_mode_select_input
);
	logic run_clk;

	initial begin
		o_shutdown_request_n = 1'b0;
		// Host still booting, keep-alive level requested
		o_mode_select_input = 1'b0;
		run_clk = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Odd start offset keeps the 160 ns burst unrelated in phase to the system clock
	initial begin
		#3.3;
		forever begin
			#80;
			if (run_clk) begin
				o_mode_select_input = ~o_mode_select_input;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic power_up();
		o_shutdown_request_n = 1'b1;
		o_mode_select_input = 1'b1;
	endtask

	task automatic set_sleep_n(input logic v);
		o_shutdown_request_n = v;
	endtask

	task automatic set_mode(input logic v);
		o_mode_select_input = v;
	endtask

	task automatic start_sync();
		run_clk = 1'b1;
	endtask

	// Burst stops with the pin parked high so PWM stays selected
	task automatic stop_sync();
		run_clk = 1'b0;
		o_mode_select_input = 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking testbench for the regulator mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import rmc_pkg::*;
	localparam int SLP = 20;
	logic i_clk = 1'b0;
	logic i_rstn;
	logic ss;
	logic pg;
	logic fault;
	logic bias;
	logic vin;
	wire shdn_n;
	wire mode;
	logic sleep, full, ka, red, pend, inh, comp, ssp, pgo, half, prot, swc, lock;
	int n_fail = 0;
	int total_checks = 0;
	int k;

	always #4 i_clk = ~i_clk;

	rmc_host_model host (
		.o_shutdown_request_n(shdn_n),
		.o_mode_select_input(mode)
	);

	rmc_mode_ctrl #(.SLEEP_DELAY_CYC_P(SLP)) dut (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_mode_clk(mode),
		.i_shutdown_request_n(shdn_n), .i_mode_select_input(mode),
		.i_ss_above_pfm_en(ss), .i_pg_detect(pg), .i_fault(fault),
		.i_bias_ok(bias), .i_vin_ok(vin),
		.o_sleep(sleep), .o_full_pwm_mode(full), .o_keep_alive_pulse_mode(ka),
		.o_reduced_limit_pwm_mode(red), .o_pfm_pending(pend), .o_switch_inhibit(inh),
		.o_comp_pull_low(comp), .o_ss_pull_low(ssp), .o_power_good_output(pgo),
		.o_half_current_limit(half), .o_protect_enable(prot), .o_sw_clk(swc),
		.o_ext_locked(lock)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// Bounded wait so a stuck output fails instead of hanging
	task automatic wait_for(input string what, ref logic s, input logic v, input int lim);
		for (int i = 0; i < lim && s !== v; i++) begin
			step(1);
		end
		check(what, s, v);
	endtask

	task automatic count_sw(input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			if (swc === 1'b1) cnt++;
			step(1);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_wake();
		host.power_up();
		wait_for("full_pwm", full, 1'b1, 12);
		check("sleep", sleep, 1'b0);
		check("inhibit", inh, 1'b0);
		check("pg_out", pgo, 1'b1);
		count_sw(96, k);
		check("base_pulses", k, 4);
		$display("test wake done");
	endtask

	task automatic t_keep_alive();
		ss = 1'b1;
		host.set_mode(1'b0);
		wait_for("pending", pend, 1'b1, 8);
		step(2030);
		check("early_keep_alive", ka, 1'b0);
		wait_for("keep_alive", ka, 1'b1, 40);
		check("full_in_ka", full, 1'b0);
		check("protect_in_ka", prot, 1'b0);
		count_sw(48, k);
		check("ka_pulses", k, 0);
		fault = 1'b1;
		wait_for("reduced", red, 1'b1, 8);
		check("half_limit", half, 1'b1);
		check("protect", prot, 1'b1);
		check("comp_low", comp, 1'b1);
		check("inhibit", inh, 1'b1);
		fault = 1'b0;
		wait_for("back_ka", ka, 1'b1, 8);
		host.set_mode(1'b1);
		wait_for("ka_exit", full, 1'b1, 8);
		$display("test keep_alive done");
	endtask

	task automatic t_abort();
		host.set_mode(1'b0);
		wait_for("pending_a", pend, 1'b1, 8);
		step(1000);
		host.set_mode(1'b1);
		wait_for("abort_mode", pend, 1'b0, 8);
		step(1100);
		check("ka_after_abort", ka, 1'b0);
		host.set_mode(1'b0);
		wait_for("pending_b", pend, 1'b1, 8);
		step(500);
		ss = 1'b0;
		wait_for("abort_ss", pend, 1'b0, 8);
		step(1600);
		check("ka_after_ss", ka, 1'b0);
		check("full_kept", full, 1'b1);
		ss = 1'b1;
		wait_for("pending_c", pend, 1'b1, 8);
		pg = 1'b0;
		wait_for("abort_pg", pend, 1'b0, 8);
		check("pg_out_low", pgo, 1'b0);
		check("full_pg", full, 1'b1);
		host.set_mode(1'b1);
		pg = 1'b1;
		step(8);
		$display("test abort done");
	endtask

	task automatic t_sleep();
		host.set_sleep_n(1'b0);
		step(10);
		check("glitch_inhibit", inh, 1'b1);
		check("glitch_comp", comp, 1'b1);
		host.set_sleep_n(1'b1);
		step(30);
		check("glitch_sleep", sleep, 1'b0);
		host.set_sleep_n(1'b0);
		step(12);
		check("early_sleep", sleep, 1'b0);
		wait_for("sleep", sleep, 1'b1, 20);
		check("full_off", full, 1'b0);
		check("ss_low", ssp, 1'b1);
		host.set_mode(1'b0);
		step(20);
		check("mode_ignored", pend, 1'b0);
		check("still_sleep", sleep, 1'b1);
		host.set_mode(1'b1);
		host.set_sleep_n(1'b1);
		wait_for("rewake", full, 1'b1, 12);
		$display("test sleep done");
	endtask

	task automatic t_sync();
		host.start_sync();
		wait_for("locked", lock, 1'b1, 200);
		count_sw(200, k);
		check("sync_pulses", k, 10);
		check("no_ka_sync", ka, 1'b0);
		host.stop_sync();
		wait_for("unlock", lock, 1'b0, 70);
		check("full_after", full, 1'b1);
		$display("test sync done");
	endtask

	task automatic t_bias();
		bias = 1'b0;
		wait_for("bias_ss", ssp, 1'b1, 8);
		check("bias_pg", pgo, 1'b0);
		check("bias_comp", comp, 1'b1);
		check("bias_inh", inh, 1'b1);
		bias = 1'b1;
		wait_for("bias_back", full, 1'b1, 40);
		// Input supply gone first: bias loss alone must not reset
		vin = 1'b0;
		step(4);
		bias = 1'b0;
		step(8);
		check("vin_first_ss", ssp, 1'b0);
		check("vin_first_full", full, 1'b1);
		bias = 1'b1;
		vin = 1'b1;
		step(4);
		$display("test bias done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_rstn = 1'b0;
		ss = 1'b0;
		pg = 1'b1;
		fault = 1'b0;
		bias = 1'b1;
		vin = 1'b1;
		// Link flops only clock on the mode pin: pulse it in reset so they settle
		repeat (4) begin
			@(posedge i_clk);
			#1;
			host.set_mode(1'b1);
			@(posedge i_clk);
			#1;
			host.set_mode(1'b0);
		end
		i_rstn = 1'b1;
		step(2);
		t_wake();
		t_keep_alive();
		t_abort();
		t_sleep();
		t_sync();
		t_bias();
		test_done();
	end

	// Tests need about 7k cycles; allow about seven times that
	initial begin
		#400000;
		n_fail++;
		test_done();
	end
endmodule
`default_nettype wire
